// >>> pmsc_regs.vh
// Register offsets, field positions and reset values of the capability bank
`ifndef PMSC_REGS_VH
`define PMSC_REGS_VH
`define PMSC_OFF_MSI_CTRL      12'h050
`define PMSC_OFF_MSIX_CTRL     12'h068
`define PMSC_OFF_MSIX_TABLE    12'h06C
`define PMSC_OFF_MSIX_PBA      12'h070
`define PMSC_OFF_PCIE_CAP      12'h080
`define PMSC_OFF_SLOT_CAP      12'h094
`define PMSC_OFF_SLOT_POWER    12'h098
`define PMSC_MMC_LSB           16
`define PMSC_MMC_MSB           31
`define PMSC_TSIZE_LSB         16
`define PMSC_TSIZE_MSB         26
`define PMSC_BIR_MSB           2
`define PMSC_SLOT_IMPL_BIT     24
`define PMSC_SP_LIMIT_LSB      7
`define PMSC_SP_LIMIT_MSB      14
`define PMSC_SP_SCALE_LSB      15
`define PMSC_SP_SCALE_MSB      16
`define PMSC_SLOTNUM_LSB       19
`define PMSC_SLOTNUM_MSB       31
`define PMSC_SP_SCALE_RST      2'h0
`define PMSC_SP_LIMIT_RST      8'h00
`endif

// >>> pmsc_capability_regs.v
// APB register bank for MSI, MSI-X and slot capability fields
// Operation
// - Advertise MSI vector count 1..16 at 0x050
// - Memory-mapped variant advertises exactly one vector
// - MSI-X visible only if enabled and streaming
// - Table size minus one, bits 26:16
// - Table offset low 3 bits carry BIR
// - Table BAR indicator, read-only, 0 to 5
// - PBA offset low 3 bits carry BIR
// - PBA BAR indicator, read-only, 0 to 5
// - Slot capability only in Root Port with slot
// - Slot implemented bit when slot recorded
// - Power scale encodes 1.0x down to 0.001x
// - Power scale resets to 00
// - Slot power write sends power limit message
// - Eight-bit power limit value
`timescale 1ns/1ps
`include "pmsc_regs.vh"
module pmsc_capability_regs #(
    parameter [4:0]  MSI_VECTORS   = 5'h01,     // 1,2,4,8 or 16
    parameter        MM_VARIANT    = 0,         // Memory-mapped application interface
    parameter        MSIX_ENABLE   = 0,
    parameter [10:0] MSIX_TSIZE    = 11'h000,   // Table size minus one
    parameter [31:0] MSIX_TABLE    = 32'h00001000, // Offset, low 3 bits ignored
    parameter [2:0]  MSIX_TBIR     = 3'h5,
    parameter [31:0] MSIX_PBA      = 32'h00002000,
    parameter [2:0]  MSIX_PBIR     = 3'h4,
    parameter        ROOT_PORT     = 0,
    parameter        SLOT_PRESENT  = 0,
    parameter [12:0] SLOT_NUMBER   = 13'h1ABC
) (
    input  wire        clock,          // 20 MHz clock
    input  wire        rst,            // Async reset, active high
    input  wire        psel,           // APB select
    input  wire        penable,        // APB access phase
    input  wire        pwrite,         // APB write
    input  wire [11:0] paddr,          // APB byte address
    input  wire [31:0] pwdata,         // APB write data
    output reg  [31:0] prdata,         // APB read data
    output reg         pready,         // APB ready
    output reg         pslverr,        // APB error, always low
    output reg         power_msg_ff    // Set_Slot_Power_Limit request pulse
);
    reg  [1:0]  scale_ff;
    reg  [7:0]  limit_ff;
    reg  [31:0] nxt_rdata;
    reg  [2:0]  log2v;

    wire msix_on = (MSIX_ENABLE != 0) && (MM_VARIANT == 0);
    wire slot_on = (ROOT_PORT != 0) && (SLOT_PRESENT != 0);
    wire setup   = psel && !penable;
    wire wr_acc  = psel && penable && pwrite && pready;

    // Encoded vector count, power of two
    always @* begin
        log2v = 3'h0;
        if (MM_VARIANT != 0)
            log2v = 3'h0;
        else if (MSI_VECTORS >= 5'h10)
            log2v = 3'h4;
        else if (MSI_VECTORS >= 5'h08)
            log2v = 3'h3;
        else if (MSI_VECTORS >= 5'h04)
            log2v = 3'h2;
        else if (MSI_VECTORS >= 5'h02)
            log2v = 3'h1;
    end

    // Unmapped and disabled capabilities read as zero
    always @* begin
        nxt_rdata = 32'h00000000;
        case (paddr)
            `PMSC_OFF_MSI_CTRL: begin
                nxt_rdata[`PMSC_MMC_LSB+3:`PMSC_MMC_LSB+1] = log2v;
            end
            `PMSC_OFF_MSIX_CTRL: begin
                if (msix_on)
                    nxt_rdata[`PMSC_TSIZE_MSB:`PMSC_TSIZE_LSB] = MSIX_TSIZE;
            end
            `PMSC_OFF_MSIX_TABLE: begin
                if (msix_on)
                    nxt_rdata = {MSIX_TABLE[31:3], MSIX_TBIR};
            end
            `PMSC_OFF_MSIX_PBA: begin
                if (msix_on)
                    nxt_rdata = {MSIX_PBA[31:3], MSIX_PBIR};
            end
            `PMSC_OFF_PCIE_CAP: begin
                nxt_rdata[`PMSC_SLOT_IMPL_BIT] = slot_on;
            end
            `PMSC_OFF_SLOT_CAP: begin
                if (slot_on) begin
                    nxt_rdata[`PMSC_SP_LIMIT_MSB:`PMSC_SP_LIMIT_LSB] = limit_ff;
                    nxt_rdata[`PMSC_SP_SCALE_MSB:`PMSC_SP_SCALE_LSB] = scale_ff;
                    nxt_rdata[`PMSC_SLOTNUM_MSB:`PMSC_SLOTNUM_LSB] = SLOT_NUMBER;
                end
            end
            `PMSC_OFF_SLOT_POWER: begin
                if (slot_on)
                    nxt_rdata[9:0] = {scale_ff, limit_ff};
            end
            default: begin
                nxt_rdata = 32'h00000000;
            end
        endcase
    end

    // No wait state: ready rises in the first access cycle
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata       <= 32'h00000000;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            power_msg_ff <= 1'b0;
            scale_ff     <= `PMSC_SP_SCALE_RST;
            limit_ff     <= `PMSC_SP_LIMIT_RST;
        end else begin
            pslverr      <= 1'b0;
            pready       <= setup;
            power_msg_ff <= 1'b0;
            if (setup && !pwrite)
                prdata <= nxt_rdata;
            // Only the power setting is writable; all else ignored
            if (wr_acc && slot_on && paddr == `PMSC_OFF_SLOT_POWER) begin
                limit_ff     <= pwdata[7:0];
                scale_ff     <= pwdata[9:8];
                power_msg_ff <= 1'b1;
            end
        end
    end
endmodule

// >>> pmsc_properties.sv
// Bus and message assertions for the capability register bank
`timescale 1ns/1ps
module pmsc_properties (
    input wire        clock,        // Clock
    input wire        rst,          // Reset
    input wire        psel,         // Select
    input wire        penable,      // Access
    input wire        pwrite,       // Write
    input wire [11:0] paddr,        // Address
    input wire [31:0] pwdata,       // Write data
    input wire [31:0] prdata,       // Read data
    input wire        pready,       // Ready
    input wire        pslverr,      // Error
    input wire        power_msg_ff  // Message pulse
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence setup_s; psel && !penable; endsequence
    sequence pwr_s; psel && penable && pwrite && paddr == 12'h098; endsequence
    a_ready_after_setup: assert property (setup_s |=> pready) else $error("no ready");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("long ready");
    a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray ready");
    a_never_error: assert property (!pslverr) else $error("error response");
    a_msg_follows: assert property (pwr_s |=> power_msg_ff) else $error("no message");
    a_msg_cause: assert property (power_msg_ff |-> $past(psel & penable & pwrite)
        && $past(paddr) == 12'h098) else $error("stray message");
    a_msg_one_cycle: assert property (power_msg_ff |=> !power_msg_ff) else $error("long msg");
    a_rdata_hold: assert property ($changed(prdata) |-> $past(psel & !penable & !pwrite))
        else $error("read data moved");
endmodule
bind pmsc_capability_regs pmsc_properties u_pmsc_properties (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_msg_ff(power_msg_ff));

// >>> test_pcie_msi_slot_capability_regs.sv
// Self-checking bench for the capability register bank
`timescale 1ns/1ps
module test_pcie_msi_slot_capability_regs;
    reg clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h00000000, rd;
    wire [31:0] prdata;
    wire        pready, pslverr, power_msg_ff;
    integer     n_fail = 0, num_checks = 0, s;
    pmsc_capability_regs #(.MSI_VECTORS(5'h08), .MSIX_ENABLE(1), .MSIX_TSIZE(11'h7FF),
        .ROOT_PORT(1), .SLOT_PRESENT(1)) u_pmsc_capability_regs (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_msg_ff(power_msg_ff));
    initial forever #25 clock = ~clock;
    task chk(input [8*8-1:0] nm, input [31:0] seen, input [31:0] exp); begin
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            $display("unexpected %0s exp %h seen %h", nm, exp, seen);
            n_fail = n_fail + 1;
        end
    end endtask
    // Starts after an edge so back-to-back calls never assign twice in one step
    task apb(input w, input [11:0] a, input [31:0] d); begin
        @(posedge clock);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock) penable <= 1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        chk("err", pslverr, 0);
        psel <= 0; penable <= 0;
        #1;
    end endtask
    task t_msi_msix; begin
        apb(0, 12'h050, 0); chk("mmc", rd[19:17], 3);
        apb(1, 12'h068, 0); apb(0, 12'h068, 0); chk("tsize", rd[26:16], 11'h7FF);
        apb(0, 12'h06C, 0); chk("table", rd, 32'h00001005);
        apb(1, 12'h070, 0); apb(0, 12'h070, 0); chk("pba", rd, 32'h00002004);
        $display("test msi_msix done");
    end endtask
    task t_slot; begin
        apb(0, 12'h080, 0); chk("slotimp", rd[24], 1);
        apb(0, 12'h094, 0); chk("scale0", rd[16:15], 0);
        chk("slotnum", rd[31:19], 13'h1ABC);
        apb(1, 12'hFFC, 32'h000003FF); chk("nomsg", power_msg_ff, 0);
        for (s = 0; s < 4; s = s + 1) begin
            apb(1, 12'h098, {22'h0, s[1:0], 8'hA5 + s[7:0]}); chk("msg", power_msg_ff, 1);
            apb(0, 12'h094, 0); chk("scale", rd[16:15], s[1:0]);
            chk("limit", rd[14:7], 8'hA5 + s[7:0]);
        end
        $display("test slot done");
    end endtask
    // Mid-run reset must return the power setting to zero
    task t_reset; begin
        @(posedge clock) rst <= 1;
        repeat (2) @(posedge clock);
        rst <= 0;
        apb(0, 12'h094, 0); chk("rscale", rd[16:15], 0);
        chk("rlimit", rd[14:7], 0);
        $display("test reset done");
    end endtask
    task print_verdict; begin
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    end endtask
    initial begin
        #100000 n_fail = n_fail + 1;
        print_verdict;
    end
    initial begin
        repeat (2) @(posedge clock);
        rst <= 0;
        t_msi_msix;
        t_slot;
        t_reset;
        print_verdict;
    end
endmodule
